// >>> hdl/tcu_params.svh
// Purpose: Constants for the two-channel timer core.
// Assumes: Byte registers, one per aligned 32-bit word.
// Notes:   Offsets are byte addresses.
`ifndef TCU_PARAMS_SVH
`define TCU_PARAMS_SVH
// ==========================================
// Register offsets
`define TCU_OFS_CTRL   6'h00
`define TCU_OFS_CNTH   6'h04
`define TCU_OFS_CNTL   6'h08
`define TCU_OFS_MODH   6'h0C
`define TCU_OFS_MODL   6'h10
`define TCU_OFS_CH0C   6'h14
`define TCU_OFS_CH0H   6'h18
`define TCU_OFS_CH0L   6'h1C
`define TCU_OFS_CH1C   6'h20
`define TCU_OFS_CH1H   6'h24
`define TCU_OFS_CH1L   6'h28
`define TCU_CH_STRIDE  6'h0C
// ==========================================
// Field positions
`define TCU_B_FLAG     7
`define TCU_B_IE       6
`define TCU_B_STOP     5
`define TCU_B_CLR      4
`define TCU_B_MSB      5
`define TCU_B_MSA      4
`define TCU_B_ELSB     3
`define TCU_B_ELSA     2
`define TCU_B_TOV      1
`define TCU_B_MAX      0
// ==========================================
// Reset values and counts
`define TCU_RST_MOD    16'hFFFF
`define TCU_RST_STOP   1'h1
`define TCU_DIV_EXT    3'h7
`define TCU_NCH        2
`endif

// >>> hdl/tcu_pkg.sv
// Purpose: Types for the two-channel timer core.
// Assumes: Constants come from tcu_params.svh.
// Notes:   State is one packed struct.
package tcu_pkg;
  typedef struct packed {
    logic ie;
    logic msb;
    logic msa;
    logic elsb;
    logic elsa;
    logic tov;
    logic max;
  } tcu_chctl_t;
  typedef struct packed {
    tcu_chctl_t  ctl;
    logic        flag;
    logic        armed;
    logic [15:0] val;
    logic        lock;
    logic        pin;
    logic        maxact;
  } tcu_ch_t;
  typedef struct packed {
    logic [1:0] out;
    logic [1:0] oe_n;
  } tcu_pins_t;
  typedef struct packed {
    tcu_ch_t [1:0]   ch;
    logic [15:0]     cnt;
    logic [15:0]     modv;
    logic [5:0]      presc;
    logic            wflag;
    logic            warmed;
    logic            wie;
    logic            stop;
    logic [2:0]      div;
    logic            latched;
    logic [7:0]      cnt_buf;
    logic            mod_lock;
    logic            cnt_upd;
    logic [2:0]      ext_s;
    logic [1:0][2:0] pin_s;
    logic            buf_sel;
    logic            buf_last;
    logic            ack;
    logic [7:0]      rdata;
  } tcu_state_t;
endpackage

// >>> hdl/tcu_core.sv
// Purpose: Two-channel 16-bit timer with capture, compare and PWM.
// Assumes: Avalon-MM slave, byte registers on word addresses.
// Notes:   Every bus access answers one cycle after it is raised.
`timescale 1ns/10ps
`default_nettype none
`include "tcu_params.svh"

// Function
// - Divider select 0..6 picks bus clock /1../64; 7 picks external count clock.
// - Counter high read latches low byte until low byte is read.
// - Reset and the counter clear bit zero the counter.
// - Counter equal to limit sets wrap flag; next tick restarts at zero.
// - Limit high write suppresses wrap flag until limit low write.
// - Reset loads limit with all ones.
// - Channel flag sets on active capture edge or compare match.
// - Flag clears by read with flag set then write 0; new event wins.
// - Channel request is flag and enable together; channel 1 also needs the buffered bit clear.
// - Buffered bit on channel 0 links channels and frees channel 1 pin.
// - Mode bit selects capture or compare; with edge bits 00 presets pin.
// - Edge bits 00 leave the pin under port control.
// - Capture edge: 01 rising, 10 falling, 11 both.
// - Compare action: 00 none, 01 toggle, 10 clear, 11 set.
// - Wrap action beats a coinciding compare action.
// - Max duty bit forces full duty from the next period.
// - Channel value holds capture or compare value; reset value zero.
// - Capture high read blocks captures until low read.
// - Compare high write blocks matches until low write.
// - Stop bit holds the counter; reset sets it.
module tcu_core
  import tcu_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic        ext_count_clock,
  input  wire logic [1:0]  channel_pin_in,
  output tcu_pins_t        channel_pin,
  output logic             irq_wrap,
  output logic [1:0]       irq_channel
);

  // ==========================================
  // Helpers

  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = (a[5:2] == ofs[5:2]);
  endfunction

  function automatic logic div_tick(input logic [2:0] sel, input logic [5:0] p, input logic ext);
    logic [5:0] mask;
    mask = 6'h3F >> (3'h6 - sel);
    if (sel == `TCU_DIV_EXT) begin
      div_tick = ext;
    end else if (sel == 3'h0) begin
      div_tick = 1'b1;
    end else begin
      div_tick = ((p & mask) == mask);
    end
  endfunction

  function automatic logic [7:0] ctl_byte(input tcu_ch_t c);
    ctl_byte = {c.flag, c.ctl.ie, c.ctl.msb, c.ctl.msa, c.ctl.elsb, c.ctl.elsa, c.ctl.tov, c.ctl.max};
  endfunction

  // ==========================================
  // State

  tcu_state_t s;
  tcu_state_t next_s;

  logic req;
  logic rd;
  logic wr;
  logic tick;
  logic wrap_hit;
  logic wrap_evt;
  logic [7:0] wd;
  logic [1:0] oe_n_c;

  assign req = (read | write) & ~s.ack;
  assign rd = req & read;
  assign wr = req & write & byteenable[0];
  assign wd = writedata[7:0];
  assign waitrequest = (read | write) & ~s.ack;
  assign readdata = {24'h000000, s.rdata};

  // Wrap is judged when a new count shows, so the flag follows the value.
  assign wrap_hit = s.cnt_upd & (s.cnt == s.modv);
  assign wrap_evt = wrap_hit & ~s.mod_lock;

  // ==========================================
  // Next state

  always_comb begin
    logic ext_rise;
    logic off1;
    logic buffered;
    logic cap_mode;
    logic cmpf;
    logic cmp_pin;
    logic rise;
    logic fall;
    logic cap_evt;
    logic cmp_evt;
    logic force_full;
    logic hold;
    logic [1:0] els;
    logic [15:0] cmpv;
    logic [5:0] ofs;
    ext_rise = 1'b0;
    off1 = 1'b0;
    buffered = 1'b0;
    cap_mode = 1'b0;
    cmpf = 1'b0;
    cmp_pin = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    cap_evt = 1'b0;
    cmp_evt = 1'b0;
    force_full = 1'b0;
    hold = 1'b0;
    els = 2'h0;
    cmpv = 16'h0000;
    ofs = 6'h00;
    oe_n_c = 2'h3;
    next_s = s;
    next_s.ack = req;
    next_s.cnt_upd = 1'b0;

    // Synchronisers; stage 0 feeds only stage 1.
    next_s.ext_s = {s.ext_s[1:0], ext_count_clock};
    for (int i = 0; i < `TCU_NCH; i++) begin
      next_s.pin_s[i] = {s.pin_s[i][1:0], channel_pin_in[i]};
    end
    ext_rise = s.ext_s[1] & ~s.ext_s[2];

    // Counter and prescaler.
    next_s.presc = s.presc + 6'h01;
    tick = div_tick(s.div, s.presc, ext_rise) & ~s.stop;
    if (tick) begin
      next_s.cnt_upd = 1'b1;
      if (s.cnt == s.modv) begin
        next_s.cnt = 16'h0000;
      end else begin
        next_s.cnt = s.cnt + 16'h0001;
      end
    end
    if (wrap_hit) begin
      next_s.buf_sel = s.buf_last;
    end

    // Bus reads with their side effects.
    if (rd) begin
      next_s.rdata = 8'h00;
      if (hit(address, `TCU_OFS_CTRL)) begin
        next_s.rdata = {s.wflag, s.wie, s.stop, 1'b0, 1'b0, s.div};
        next_s.warmed = s.wflag;
      end
      if (hit(address, `TCU_OFS_CNTH)) begin
        next_s.rdata = s.cnt[15:8];
        if (!s.latched) begin
          next_s.latched = 1'b1;
          next_s.cnt_buf = s.cnt[7:0];
        end
      end
      if (hit(address, `TCU_OFS_CNTL)) begin
        next_s.rdata = s.latched ? s.cnt_buf : s.cnt[7:0];
        next_s.latched = 1'b0;
      end
      if (hit(address, `TCU_OFS_MODH)) begin
        next_s.rdata = s.modv[15:8];
      end
      if (hit(address, `TCU_OFS_MODL)) begin
        next_s.rdata = s.modv[7:0];
      end
    end

    // Bus writes to the timer registers.
    if (wr && hit(address, `TCU_OFS_CTRL)) begin
      next_s.wie = wd[`TCU_B_IE];
      next_s.stop = wd[`TCU_B_STOP];
      next_s.div = wd[2:0];
      next_s.warmed = 1'b0;
      if (!wd[`TCU_B_FLAG] && s.warmed) begin
        next_s.wflag = 1'b0;
      end
      if (wd[`TCU_B_CLR]) begin
        next_s.cnt = 16'h0000;
        next_s.presc = 6'h00;
        next_s.cnt_upd = 1'b0;
      end
    end
    if (wr && hit(address, `TCU_OFS_MODH)) begin
      next_s.modv[15:8] = wd;
      next_s.mod_lock = 1'b1;
    end
    if (wr && hit(address, `TCU_OFS_MODL)) begin
      next_s.modv[7:0] = wd;
      next_s.mod_lock = 1'b0;
    end

    // A new wrap kills a pending clear, and the set wins.
    if (wrap_evt) begin
      next_s.wflag = 1'b1;
      next_s.warmed = 1'b0;
    end

    // ==========================================
    // Channels

    for (int i = 0; i < `TCU_NCH; i++) begin
      ofs = `TCU_OFS_CH0C + ((i == 1) ? `TCU_CH_STRIDE : 6'h00);
      els = {s.ch[i].ctl.elsb, s.ch[i].ctl.elsa};
      buffered = (i == 0) && s.ch[0].ctl.msb;
      off1 = (i == 1) && s.ch[0].ctl.msb;
      cap_mode = !off1 && !buffered && !s.ch[i].ctl.msa && (els != 2'h0);
      cmpf = !off1 && (buffered ? (els != 2'h0) : s.ch[i].ctl.msa);
      cmp_pin = cmpf && (els != 2'h0);
      rise = s.pin_s[i][1] & ~s.pin_s[i][2];
      fall = ~s.pin_s[i][1] & s.pin_s[i][2];
      cap_evt = cap_mode && !s.stop && !s.ch[i].lock
                && ((s.ch[i].ctl.elsa && rise) || (s.ch[i].ctl.elsb && fall));
      cmpv = buffered ? s.ch[s.buf_sel].val : s.ch[i].val;
      cmp_evt = cmpf && s.cnt_upd && (s.cnt == cmpv) && !s.ch[i].lock;
      force_full = s.ch[i].ctl.tov && s.ch[i].maxact;
      hold = (els != 2'h3);

      // Register reads.
      if (rd && hit(address, ofs)) begin
        next_s.rdata = ctl_byte(s.ch[i]);
        next_s.ch[i].armed = s.ch[i].flag;
      end
      if (rd && hit(address, ofs + 6'h04)) begin
        next_s.rdata = s.ch[i].val[15:8];
        if (cap_mode) begin
          next_s.ch[i].lock = 1'b1;
        end
      end
      if (rd && hit(address, ofs + 6'h08)) begin
        next_s.rdata = s.ch[i].val[7:0];
        if (cap_mode) begin
          next_s.ch[i].lock = 1'b0;
        end
      end

      // Register writes.
      if (wr && hit(address, ofs)) begin
        next_s.ch[i].ctl.ie = wd[`TCU_B_IE];
        next_s.ch[i].ctl.msb = (i == 0) ? wd[`TCU_B_MSB] : 1'b0;
        next_s.ch[i].ctl.msa = wd[`TCU_B_MSA];
        next_s.ch[i].ctl.elsb = wd[`TCU_B_ELSB];
        next_s.ch[i].ctl.elsa = wd[`TCU_B_ELSA];
        next_s.ch[i].ctl.tov = wd[`TCU_B_TOV];
        next_s.ch[i].ctl.max = wd[`TCU_B_MAX];
        next_s.ch[i].armed = 1'b0;
        if (!wd[`TCU_B_FLAG] && s.ch[i].armed) begin
          next_s.ch[i].flag = 1'b0;
        end
      end
      if (wr && hit(address, ofs + 6'h04)) begin
        next_s.ch[i].val[15:8] = wd;
        if (!cap_mode) begin
          next_s.ch[i].lock = 1'b1;
        end
      end
      if (wr && hit(address, ofs + 6'h08)) begin
        next_s.ch[i].val[7:0] = wd;
        next_s.buf_last = i[0];
        if (!cap_mode) begin
          next_s.ch[i].lock = 1'b0;
        end
      end

      // Events; the set wins over a clear in the same cycle.
      if (cap_evt) begin
        next_s.ch[i].val = s.cnt;
      end
      if (cap_evt || cmp_evt) begin
        next_s.ch[i].flag = 1'b1;
        next_s.ch[i].armed = 1'b0;
      end

      // Pin level. Max duty is sampled only at a wrap, so a change
      // waits for the next period instead of cutting a pulse short.
      if (els == 2'h0) begin
        next_s.ch[i].pin = ~s.ch[i].ctl.msa;
      end else if (cmp_pin) begin
        if (wrap_hit && s.ch[i].ctl.tov) begin
          next_s.ch[i].maxact = s.ch[i].ctl.max;
          if (s.ch[i].ctl.max) begin
            next_s.ch[i].pin = hold;
          end else begin
            next_s.ch[i].pin = ~s.ch[i].pin;
          end
        end else if (cmp_evt && !force_full) begin
          case (els)
            2'h1: next_s.ch[i].pin = ~s.ch[i].pin;
            2'h2: next_s.ch[i].pin = 1'b0;
            2'h3: next_s.ch[i].pin = 1'b1;
            default: next_s.ch[i].pin = s.ch[i].pin;
          endcase
        end
      end
      if (!s.ch[i].ctl.tov) begin
        next_s.ch[i].maxact = 1'b0;
      end
      oe_n_c[i] = ~cmp_pin;
    end
  end

  // ==========================================
  // Registers

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.modv <= `TCU_RST_MOD;
      s.stop <= `TCU_RST_STOP;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================
  // Outputs

  assign channel_pin.out = {s.ch[1].pin, s.ch[0].pin};
  assign channel_pin.oe_n = oe_n_c;
  assign irq_wrap = s.wflag & s.wie;
  assign irq_channel[0] = s.ch[0].flag & s.ch[0].ctl.ie;
  assign irq_channel[1] = s.ch[1].flag & s.ch[1].ctl.ie & ~s.ch[0].ctl.msb;

endmodule
`default_nettype wire

// >>> tb/tcu_core_checker.sv
// Purpose: Port assertions for tcu_core.
// Assumes: Control writes land on the edge where they are taken.
// Notes:   Only the control bytes, which steer pins and requests, are shadowed.
`timescale 1ns/10ps
`default_nettype none
`include "tcu_params.svh"
module tcu_core_checker
  import tcu_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic [5:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic        waitrequest,
  input wire tcu_pins_t   channel_pin,
  input wire logic        irq_wrap,
  input wire logic [1:0]  irq_channel
);
  // ==========================================
  // Shadow control bits
  logic [7:0] sh_t, sh_0, sh_1;
  logic [5:0] aw;
  logic       tk, d0, d1;
  assign aw = {address[5:2], 2'b00};
  assign tk = write && waitrequest && byteenable[0];
  assign d0 = (sh_0[5] || sh_0[4]) && (sh_0[3:2] != 2'h0);
  assign d1 = !sh_0[5] && sh_1[4] && (sh_1[3:2] != 2'h0);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sh_t <= 8'h00;
      sh_0 <= 8'h00;
      sh_1 <= 8'h00;
    end else if (tk) begin
      if (aw == `TCU_OFS_CTRL) sh_t <= writedata[7:0];
      if (aw == `TCU_OFS_CH0C) sh_0 <= writedata[7:0];
      if (aw == `TCU_OFS_CH1C) sh_1 <= writedata[7:0];
    end
  end
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  a_wait_once: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus waited more than one cycle");
  a_pin_ch0: assert property (channel_pin.oe_n[0] == !d0)
    else $error("channel 0 drive enable wrong");
  a_pin_ch1: assert property (channel_pin.oe_n[1] == !d1)
    else $error("channel 1 drive enable wrong");
  a_irq_en: assert property ((irq_channel & ~{sh_1[6], sh_0[6]}) == 2'b00)
    else $error("channel request without enable");
  a_buf_mask: assert property (sh_0[5] |-> !irq_channel[1])
    else $error("channel 1 request while linked");
  a_flag_keep: assert property ($fell(irq_channel[0]) |-> $past(tk && aw == `TCU_OFS_CH0C))
    else $error("channel 0 request dropped without a write");
  a_wrap_keep: assert property ($fell(irq_wrap) |-> $past(tk && aw == `TCU_OFS_CTRL))
    else $error("wrap request dropped without a write");
  a_wrap_en: assert property (!sh_t[6] |-> !irq_wrap)
    else $error("wrap request without enable");
endmodule
bind tcu_core tcu_core_checker i_tcu_core_checker (
  .clk_sys(clk_sys), .arst_n(arst_n), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .waitrequest(waitrequest),
  .channel_pin(channel_pin), .irq_wrap(irq_wrap), .irq_channel(irq_channel)
);
`default_nettype wire

// >>> tb/tcu_far.sv
// Purpose: Outside world of the timer pins.
// Assumes: Released pins show the outside level.
// Notes:   Count pulses stay well under half the bus clock rate.
`timescale 1ns/10ps
`default_nettype none
module tcu_far
  import tcu_pkg::*;
(
  input  wire logic      clk_sys,
  input  wire tcu_pins_t channel_pin,
  output logic [1:0]     channel_pin_in,
  output logic           ext_count_clock
);
  // ==========================================
  // Pin wires and count pulses
  logic [1:0] lvl = 2'b00;
  initial ext_count_clock = 1'b0;
  // A driven pin follows the block, so the block sees its own level.
  assign channel_pin_in = (channel_pin.oe_n & lvl) | (~channel_pin.oe_n & channel_pin.out);
  task automatic pin(input int ch, input logic v);
    lvl[ch] <= v;
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      ext_count_clock <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ext_count_clock <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_tcu_core.sv
// Purpose: Self-checking bench for tcu_core.
// Assumes: Counts come from the pin model, so they are exact.
// Notes:   Mode changes are made with the counter stopped and cleared.
`timescale 1ns/10ps
`default_nettype none
`include "tcu_params.svh"
module tb_tcu_core
  import tcu_pkg::*;
;
  logic        clk_sys, arst_n, read, write, waitrequest, ext_count_clock, irq_wrap;
  logic [5:0]  address;
  logic [31:0] writedata, readdata;
  logic [3:0]  byteenable;
  logic [1:0]  channel_pin_in, irq_channel;
  logic [7:0]  d;
  tcu_pins_t   channel_pin;
  int          err_total, samples_checked;
  // ==========================================
  // Clock, design and far side
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  tcu_core i_tcu_core (
    .clk_sys(clk_sys), .arst_n(arst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .ext_count_clock(ext_count_clock), .channel_pin_in(channel_pin_in), .channel_pin(channel_pin),
    .irq_wrap(irq_wrap), .irq_channel(irq_channel)
  );
  tcu_far i_tcu_far (
    .clk_sys(clk_sys), .channel_pin(channel_pin), .channel_pin_in(channel_pin_in),
    .ext_count_clock(ext_count_clock)
  );
  task automatic results();
    if (err_total == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cb(input logic s, input logic e);
    chk({7'h0, s}, {7'h0, e});
  endtask
  // The idle edge at the end keeps the next call from reassigning in the same step.
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] v);
    int n;
    address <= a;
    writedata <= {~v, v, ~v, v};
    read <= !w;
    write <= w;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      err_total++;
      results();
    end
    @(posedge clk_sys);
    d = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    bus(1'b1, a, v);
  endtask
  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(d, e);
  endtask
  // ==========================================
  // Scenarios
  initial begin
    arst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 6'h00;
    writedata = 32'h0;
    byteenable = 4'hF;
    err_total = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    rc(`TCU_OFS_CTRL, 8'h20);
    rc(`TCU_OFS_MODH, 8'hFF);
    rc(`TCU_OFS_MODL, 8'hFF);
    wr(6'h2C, 8'h5A);
    rc(6'h2C, 8'h00);
    // A write without the low byte lane enabled must leave the register alone.
    byteenable <= 4'hE;
    wr(`TCU_OFS_MODL, 8'h77);
    byteenable <= 4'hF;
    rc(`TCU_OFS_MODL, 8'hFF);
    wr(`TCU_OFS_CTRL, 8'h07);
    i_tcu_far.pulses(5);
    wr(`TCU_OFS_CTRL, 8'h27);
    rc(`TCU_OFS_CNTH, 8'h00);
    wr(`TCU_OFS_CTRL, 8'h37);
    i_tcu_far.pulses(2);
    rc(`TCU_OFS_CNTH, 8'h00);
    rc(`TCU_OFS_CNTL, 8'h05);
    rc(`TCU_OFS_CNTL, 8'h00);
    wr(`TCU_OFS_MODH, 8'h00);
    wr(`TCU_OFS_MODL, 8'h03);
    wr(`TCU_OFS_CTRL, 8'h47);
    i_tcu_far.pulses(2);
    cb(irq_wrap, 1'b0);
    i_tcu_far.pulses(1);
    cb(irq_wrap, 1'b1);
    i_tcu_far.pulses(1);
    rc(`TCU_OFS_CNTL, 8'h00);
    wr(`TCU_OFS_CTRL, 8'h47);
    cb(irq_wrap, 1'b1);
    rc(`TCU_OFS_CTRL, 8'hC7);
    wr(`TCU_OFS_CTRL, 8'h47);
    cb(irq_wrap, 1'b0);
    wr(`TCU_OFS_MODH, 8'h00);
    i_tcu_far.pulses(4);
    cb(irq_wrap, 1'b0);
    wr(`TCU_OFS_MODL, 8'h03);
    i_tcu_far.pulses(3);
    cb(irq_wrap, 1'b1);
    for (int e = 1; e < 4; e++) begin
      wr(`TCU_OFS_CTRL, 8'h37);
      wr(`TCU_OFS_CH0C, {4'h4, e[1:0], 2'b00});
      wr(`TCU_OFS_CTRL, 8'h07);
      i_tcu_far.pulses(e);
      i_tcu_far.pin(0, 1'b1);
      rc(`TCU_OFS_CH0C, {e[0], 3'b100, e[1:0], 2'b00});
      wr(`TCU_OFS_CH0C, {4'h4, e[1:0], 2'b00});
      i_tcu_far.pin(0, 1'b0);
      cb(irq_channel[0], e[1]);
      rc(`TCU_OFS_CH0L, 8'(e));
    end
    rc(`TCU_OFS_CH0H, 8'h00);
    i_tcu_far.pulses(2);
    i_tcu_far.pin(0, 1'b1);
    rc(`TCU_OFS_CH0L, 8'h03);
    i_tcu_far.pin(0, 1'b0);
    rc(`TCU_OFS_CH0L, 8'h01);
    for (int e = 1; e < 4; e++) begin
      wr(`TCU_OFS_CTRL, 8'h37);
      wr(`TCU_OFS_CH0C, {3'h0, (e == 3), 4'h0});
      wr(`TCU_OFS_CH0H, 8'h00);
      wr(`TCU_OFS_CH0L, 8'h02);
      wr(`TCU_OFS_CH0C, {4'h1, e[1:0], 2'b00});
      cb(channel_pin.oe_n[0], 1'b0);
      cb(channel_pin.out[0], (e != 3));
      wr(`TCU_OFS_CTRL, 8'h07);
      i_tcu_far.pulses(2);
      cb(channel_pin.out[0], (e == 3));
    end
    wr(`TCU_OFS_CTRL, 8'h37);
    wr(`TCU_OFS_CH0C, 8'h14);
    wr(`TCU_OFS_CH0H, 8'h00);
    wr(`TCU_OFS_CTRL, 8'h07);
    i_tcu_far.pulses(2);
    cb(channel_pin.out[0], 1'b1);
    wr(`TCU_OFS_CH0L, 8'h03);
    i_tcu_far.pulses(1);
    cb(channel_pin.out[0], 1'b0);
    wr(`TCU_OFS_CTRL, 8'h37);
    wr(`TCU_OFS_CH0C, 8'h00);
    wr(`TCU_OFS_CH0C, 8'h1E);
    wr(`TCU_OFS_CTRL, 8'h07);
    i_tcu_far.pulses(3);
    cb(channel_pin.out[0], 1'b0);
    i_tcu_far.pulses(4);
    cb(channel_pin.out[0], 1'b1);
    wr(`TCU_OFS_CTRL, 8'h37);
    wr(`TCU_OFS_CH1C, 8'h54);
    cb(channel_pin.oe_n[1], 1'b0);
    wr(`TCU_OFS_CH0C, 8'h24);
    cb(channel_pin.oe_n[1], 1'b1);
    cb(irq_channel[1], 1'b0);
    results();
  end
endmodule
`default_nettype wire
